// ==== src/hsp_pkg.sv ====
// constants for the strap and status pin block
package hsp_pkg;
	// strap levels
	localparam logic STRAP_LOW = 1'b0;
	localparam logic STRAP_HIGH = 1'b1;
	// values after reset
	localparam logic RST_GANG = 1'b0;
	localparam logic RST_AUTO_DIS = 1'b1;
	localparam logic RST_SERIAL_SEL = 1'b1;
	localparam logic RST_PWR_DIS = 1'b0;
	localparam logic RST_ADDR2 = 1'b0;
	// output enable is low while driving, so high means released
	localparam logic OE_RELEASED = 1'b1;
	localparam logic OE_DRIVING = 1'b0;
	// cycles from reset release before straps are caught: three stages fill, then the
	// agreement register needs one more edge before it shows the strap level
	localparam int SAMPLE_DELAY_CYC = 4;
	localparam int SAMPLE_CNT_W = 3;
	// synchroniser length for pin inputs
	localparam int SYNC_STAGES = 3;
	// downstream port that loses charging-downstream behaviour in automatic mode
	localparam int CDP_BLOCKED_PORT = 1;
	localparam int NUM_DS_PORTS = 4;
endpackage

// ==== src/hsp_strap_status.sv ====
// strap capture and status drive for the two multi-function hub pins
`timescale 1ns/1ps
`default_nettype none
module hsp_strap_status (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic gang_addr2_hs_conn_pin_in,
	output logic gang_addr2_hs_conn_pin_out,
	output logic gang_addr2_hs_conn_pin_oe_b_out,
	input wire logic auto_charge_hs_susp_pin_in,
	output logic auto_charge_hs_susp_pin_out,
	output logic auto_charge_hs_susp_pin_oe_b_out,
	input wire logic serial_slave_select_strap_in,
	input wire logic power_switch_disable_strap_in,
	input wire logic status_output_enable_in,
	input wire logic hs_upstream_connected_in,
	input wire logic hs_upstream_suspended_in,
	input wire logic upstream_connected_in,
	input wire logic auto_mode_disable_bit_wr_in,
	input wire logic auto_mode_disable_bit_wdata_in,
	output logic straps_valid_out,
	output logic ganged_power_out,
	output logic serial_bus_mode_out,
	output logic power_switch_supported_out,
	output logic addr_bit2_out,
	output logic auto_mode_disable_bit_out,
	output logic auto_charge_active_out,
	output logic [hsp_pkg::NUM_DS_PORTS-1:0] cdp_allowed_out
);
	////////////////////////////////////////////////////////////////////////
	// synchronisers
	logic gang_sync;
	logic auto_sync;
	logic serial_sync;
	logic pwr_sync;

	hsp_sync u_sync_gang (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.pin_in(gang_addr2_hs_conn_pin_in), .level_out(gang_sync));
	hsp_sync u_sync_auto (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.pin_in(auto_charge_hs_susp_pin_in), .level_out(auto_sync));
	hsp_sync u_sync_serial (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.pin_in(serial_slave_select_strap_in), .level_out(serial_sync));
	hsp_sync u_sync_pwr (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.pin_in(power_switch_disable_strap_in), .level_out(pwr_sync));

	////////////////////////////////////////////////////////////////////////
	// strap capture sequence
	// one bit holds both states, so no illegal code can appear
	typedef enum logic {HSP_WAIT, HSP_RUN} hsp_state_t;
	hsp_state_t state_reg;
	hsp_state_t state_next;
	logic [hsp_pkg::SAMPLE_CNT_W-1:0] cnt_reg;
	logic [hsp_pkg::SAMPLE_CNT_W-1:0] cnt_next;
	logic gang_reg;
	logic gang_next;
	logic auto_dis_reg;
	logic auto_dis_next;
	logic serial_reg;
	logic serial_next;
	logic pwr_dis_reg;
	logic pwr_dis_next;
	logic valid_reg;
	logic valid_next;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		gang_next = gang_reg;
		auto_dis_next = auto_dis_reg;
		serial_next = serial_reg;
		pwr_dis_next = pwr_dis_reg;
		valid_next = valid_reg;
		unique case (state_reg)
			HSP_WAIT: begin
				// the pins sit undriven here, so the synchronised level is the strap
				// straps are taken once only; later pin activity is status, not setup
				if (cnt_reg == hsp_pkg::SAMPLE_CNT_W'(hsp_pkg::SAMPLE_DELAY_CYC)) begin
					gang_next = gang_sync;
					auto_dis_next = auto_sync;
					serial_next = serial_sync;
					pwr_dis_next = pwr_sync;
					valid_next = 1'b1;
					state_next = HSP_RUN;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			HSP_RUN: begin
				if (auto_mode_disable_bit_wr_in) begin
					auto_dis_next = auto_mode_disable_bit_wdata_in;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= HSP_WAIT;
			cnt_reg <= '0;
			gang_reg <= hsp_pkg::RST_GANG;
			auto_dis_reg <= hsp_pkg::RST_AUTO_DIS;
			serial_reg <= hsp_pkg::RST_SERIAL_SEL;
			pwr_dis_reg <= hsp_pkg::RST_PWR_DIS;
			valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			gang_reg <= gang_next;
			auto_dis_reg <= auto_dis_next;
			serial_reg <= serial_next;
			pwr_dis_reg <= pwr_dis_next;
			valid_reg <= valid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// derived configuration and pin drive
	logic ganged_reg;
	logic ganged_next;
	logic smb_reg;
	logic smb_next;
	logic pwr_ok_reg;
	logic pwr_ok_next;
	logic addr2_reg;
	logic addr2_next;
	logic auto_act_reg;
	logic auto_act_next;
	logic [hsp_pkg::NUM_DS_PORTS-1:0] cdp_reg;
	logic [hsp_pkg::NUM_DS_PORTS-1:0] cdp_next;
	logic g_out_reg;
	logic g_out_next;
	logic g_oe_reg;
	logic g_oe_next;
	logic a_out_reg;
	logic a_out_next;
	logic a_oe_reg;
	logic a_oe_next;

	always_comb begin
		ganged_next = valid_reg & gang_reg & ~pwr_dis_reg;
		smb_next = valid_reg & (serial_reg == hsp_pkg::STRAP_LOW);
		pwr_ok_next = valid_reg & (pwr_dis_reg == hsp_pkg::STRAP_LOW);
		addr2_next = smb_next ? gang_reg : hsp_pkg::RST_ADDR2;
		auto_act_next = valid_reg & ~auto_dis_reg & ~upstream_connected_in;
		cdp_next = {hsp_pkg::NUM_DS_PORTS{valid_reg}};
		// block port 1 cdp
		// blocked whenever the auto mode disable bit is clear, connected or not, so the
		// port does not flip behaviour each time the upstream link comes and goes
		if (valid_reg & ~auto_dis_reg) begin
			cdp_next[hsp_pkg::CDP_BLOCKED_PORT-1] = 1'b0;
		end
		// drive only after capture when enabled
		g_oe_next = (valid_reg & status_output_enable_in) ? hsp_pkg::OE_DRIVING
			: hsp_pkg::OE_RELEASED;
		a_oe_next = g_oe_next;
		// when enabled the pins show a firm low while idle rather than floating
		// connection status on the gang pin, suspend status on the auto pin
		g_out_next = (g_oe_next == hsp_pkg::OE_DRIVING) & hs_upstream_connected_in;
		a_out_next = (a_oe_next == hsp_pkg::OE_DRIVING) & hs_upstream_suspended_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ganged_reg <= 1'b0;
			smb_reg <= 1'b0;
			pwr_ok_reg <= 1'b0;
			addr2_reg <= hsp_pkg::RST_ADDR2;
			auto_act_reg <= 1'b0;
			cdp_reg <= '0;
			g_out_reg <= 1'b0;
			g_oe_reg <= hsp_pkg::OE_RELEASED;
			a_out_reg <= 1'b0;
			a_oe_reg <= hsp_pkg::OE_RELEASED;
		end else begin
			ganged_reg <= ganged_next;
			smb_reg <= smb_next;
			pwr_ok_reg <= pwr_ok_next;
			addr2_reg <= addr2_next;
			auto_act_reg <= auto_act_next;
			cdp_reg <= cdp_next;
			g_out_reg <= g_out_next;
			g_oe_reg <= g_oe_next;
			a_out_reg <= a_out_next;
			a_oe_reg <= a_oe_next;
		end
	end

	assign straps_valid_out = valid_reg;
	assign ganged_power_out = ganged_reg;
	assign serial_bus_mode_out = smb_reg;
	assign power_switch_supported_out = pwr_ok_reg;
	assign addr_bit2_out = addr2_reg;
	assign auto_mode_disable_bit_out = auto_dis_reg;
	assign auto_charge_active_out = auto_act_reg;
	assign cdp_allowed_out = cdp_reg;
	assign gang_addr2_hs_conn_pin_out = g_out_reg;
	assign gang_addr2_hs_conn_pin_oe_b_out = g_oe_reg;
	assign auto_charge_hs_susp_pin_out = a_out_reg;
	assign auto_charge_hs_susp_pin_oe_b_out = a_oe_reg;
endmodule
`default_nettype wire

// ==== src/hsp_sync.sv ====
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module hsp_sync (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic pin_in,
	output logic level_out
);
	logic [2:0] stage_reg;
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;

	always_comb begin
		stage_next = {stage_reg[1:0], pin_in};
		level_next = level_reg;
		// first stage feeds only the second
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage_reg <= 3'h0;
			level_reg <= 1'b0;
		end else begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;
endmodule
`default_nettype wire

// ==== tb/hsp_board.sv ====
// board straps and status monitor for the two pins
`timescale 1ns/1ps
`default_nettype none
module hsp_board (
	input wire logic gang_strap_in,
	input wire logic auto_strap_in,
	input wire logic gang_drv_in,
	input wire logic gang_oe_b_in,
	input wire logic auto_drv_in,
	input wire logic auto_oe_b_in,
	output logic gang_pin_out,
	output logic auto_pin_out
);
// strap resistor wins while the device lets go of the pin
assign gang_pin_out = gang_oe_b_in ? gang_strap_in : gang_drv_in;
assign auto_pin_out = auto_oe_b_in ? auto_strap_in : auto_drv_in;
endmodule
`default_nettype wire

// ==== tb/hsp_strap_status_chk_asserts.sv ====
// checker for the strap and status pin block
`timescale 1ns/1ps
`default_nettype none
module hsp_strap_status_chk (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic gang_addr2_hs_conn_pin_out,
	input wire logic gang_addr2_hs_conn_pin_oe_b_out,
	input wire logic auto_charge_hs_susp_pin_out,
	input wire logic auto_charge_hs_susp_pin_oe_b_out,
	input wire logic status_output_enable_in,
	input wire logic hs_upstream_connected_in,
	input wire logic hs_upstream_suspended_in,
	input wire logic upstream_connected_in,
	input wire logic straps_valid_out,
	input wire logic ganged_power_out,
	input wire logic serial_bus_mode_out,
	input wire logic power_switch_supported_out,
	input wire logic addr_bit2_out,
	input wire logic auto_charge_active_out,
	input wire logic [hsp_pkg::NUM_DS_PORTS-1:0] cdp_allowed_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!rst_b_in);
pins_released_a: assert property (!straps_valid_out |-> gang_addr2_hs_conn_pin_oe_b_out &&
	auto_charge_hs_susp_pin_oe_b_out) else $error("pin driven before capture");
off_release_a: assert property (straps_valid_out && !status_output_enable_in |=>
	gang_addr2_hs_conn_pin_oe_b_out && auto_charge_hs_susp_pin_oe_b_out) else $error("pin not freed");
conn_drive_a: assert property (straps_valid_out && status_output_enable_in |=>
	!gang_addr2_hs_conn_pin_oe_b_out && gang_addr2_hs_conn_pin_out == $past(hs_upstream_connected_in))
	else $error("connection status wrong");
susp_drive_a: assert property (straps_valid_out && status_output_enable_in |=>
	!auto_charge_hs_susp_pin_oe_b_out && auto_charge_hs_susp_pin_out == $past(hs_upstream_suspended_in))
	else $error("suspend status wrong");
addr_mode_a: assert property (!serial_bus_mode_out |-> !addr_bit2_out) else $error("address bit");
gang_power_a: assert property (ganged_power_out |-> power_switch_supported_out) else $error("gang");
auto_unconn_a: assert property (auto_charge_active_out |-> !$past(upstream_connected_in))
	else $error("auto charge while connected");
port1_cdp_a: assert property (auto_charge_active_out |-> !cdp_allowed_out[0]) else $error("cdp");
endmodule
bind hsp_strap_status hsp_strap_status_chk chk (.*);
`default_nettype wire

// ==== tb/hub_strap_status_pins_test.sv ====
// self-checking bench for the strap and status pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t got %b", $time, a); end end
module hub_strap_status_pins_test;
logic clk_sys_in = 1'b0, rst_b_in = 1'b0, gs = 1'b0, as = 1'b0, ser = 1'b0, pwr = 1'b0;
logic en = 1'b0, hc = 1'b0, hsu = 1'b0, uc = 1'b1, wr = 1'b0, wd = 1'b0;
logic gpi, gpo, goe, api, apo, aoe, sv, gp, sbm, pss, a2, adb, aca;
logic [3:0] cdp;
int n_mismatch = 0, num_checks = 0, cyc = 0;
// rows: gang, auto, serial, power straps then ganged, bus mode, switching, addr2, auto bit
// gang strapped low whenever auto charging is enabled
logic [8:0] rows [4] = '{9'h00C, 9'h19F, 9'h1D5, 9'h1E1};
hsp_strap_status dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
	.gang_addr2_hs_conn_pin_in(gpi), .gang_addr2_hs_conn_pin_out(gpo),
	.gang_addr2_hs_conn_pin_oe_b_out(goe), .auto_charge_hs_susp_pin_in(api),
	.auto_charge_hs_susp_pin_out(apo), .auto_charge_hs_susp_pin_oe_b_out(aoe),
	.serial_slave_select_strap_in(ser), .power_switch_disable_strap_in(pwr),
	.status_output_enable_in(en), .hs_upstream_connected_in(hc),
	.hs_upstream_suspended_in(hsu), .upstream_connected_in(uc),
	.auto_mode_disable_bit_wr_in(wr), .auto_mode_disable_bit_wdata_in(wd),
	.straps_valid_out(sv), .ganged_power_out(gp), .serial_bus_mode_out(sbm),
	.power_switch_supported_out(pss), .addr_bit2_out(a2), .auto_mode_disable_bit_out(adb),
	.auto_charge_active_out(aca), .cdp_allowed_out(cdp));
hsp_board board (.gang_strap_in(gs), .auto_strap_in(as), .gang_drv_in(gpo),
	.gang_oe_b_in(goe), .auto_drv_in(apo), .auto_oe_b_in(aoe),
	.gang_pin_out(gpi), .auto_pin_out(api));
task automatic end_of_test;
	$display("checks %0d mismatches %0d", num_checks, n_mismatch);
	if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
task automatic do_reset;
	@(negedge clk_sys_in);
	rst_b_in = 1'b0;
	repeat (2) @(negedge clk_sys_in);
	rst_b_in = 1'b1;
endtask
task automatic wait_n(input int n);
	repeat (n) @(negedge clk_sys_in);
endtask
initial begin
	forever #50 clk_sys_in = ~clk_sys_in;
end
// ceiling well above the roughly 80 cycles the run needs
always @(posedge clk_sys_in) begin
	cyc++;
	if (cyc == 1000) begin
		n_mismatch++;
		end_of_test();
	end
end
initial begin
	foreach (rows[i]) begin
		{gs, as, ser, pwr} = rows[i][8:5];
		do_reset();
		wait_n(7);
		`CHK({sv, gp, sbm, pss, a2, adb}, {1'b1, rows[i][4:0]})
		// late strap changes must not move the captured setup
		{gs, as, ser, pwr} = ~rows[i][8:5];
		wait_n(6);
		`CHK({gp, sbm, pss, a2, adb}, rows[i][4:0])
	end
	{gs, as, ser, pwr, en, hc} = 6'h03;
	do_reset();
	`CHK({goe, aoe}, 2'h3)
	wr = 1'b1;
	wd = 1'b1;
	wait_n(1);
	wr = 1'b0;
	wait_n(6);
	`CHK(adb, 1'b0)
	`CHK({goe, gpi, aoe, api}, 4'h4)
	{hc, hsu, uc} = 3'h2;
	wait_n(2);
	`CHK({goe, gpi, aoe, api, aca, cdp}, 9'h03E)
	{en, uc} = 2'h1;
	wait_n(2);
	`CHK({goe, aoe, aca}, 3'h6)
	wr = 1'b1;
	wait_n(1);
	wr = 1'b0;
	wait_n(1);
	`CHK(adb, 1'b1)
	end_of_test();
end
endmodule
`default_nettype wire
